// ---- core/vcap_pkg.sv ----
package vcap_pkg;
   // Register byte offsets
   localparam logic [7:0] CTL_OFFSET = 8'h00;
   localparam logic [7:0] STAT_OFFSET = 8'h04;
   localparam logic [7:0] LINE_OFFSET = 8'h08;
   // Control word fields
   localparam int CHAN_RESET_POS = 31;
   localparam int BLOCK_POS = 30;
   localparam int FIELD_INVERT_BIT_POS = 20;
   localparam int LINE_COUNTER_RESET_SELECT_POS = 17;
   localparam int ENABLE_POS = 15;
   localparam logic [31:0] CTL_RESET = 32'h40020010;
   localparam logic [31:0] CTL_WMASK = 32'h4013FDF3;
   // Status fields, write one to clear
   localparam int F1_DONE_POS = 0;
   localparam int F2_DONE_POS = 1;
   localparam int FRM_DONE_POS = 2;
   localparam int STAT_WIDTH = 3;
   localparam logic [STAT_WIDTH-1:0] STAT_RESET = 3'h0;
   localparam int LINE_WIDTH = 12;
   typedef enum logic [2:0] {
      CH_IDLE = 3'b001,
      CH_DRAIN = 3'b010,
      CH_FLUSH = 3'b100
   } chan_state_t;
endpackage

// ---- core/line_counter.sv ----
`timescale 1ns/1ps
`default_nettype none
module line_counter #(
   parameter int WIDTH = vcap_pkg::LINE_WIDTH
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic restart,
   input wire logic video_mode,
   input wire logic reset_select,
   input wire logic line_eav,
   input wire logic v_bit,
   input wire logic ctl2_level,
   output logic [WIDTH-1:0] count,
   output logic count_reset
);
   import vcap_pkg::*;

   initial begin
      if (WIDTH < 2 || WIDTH > 16) begin
         $error("line_counter: WIDTH out of range");
      end
   end

   logic v_last_q;
   logic ctl2_last_q;
   logic [WIDTH-1:0] count_q;
   wire blank_start;
   wire blank_end;
   wire eav_v1_first;
   wire eav_v0_first;

   // First EAV of each blanking edge, or the matching control-input edge
   assign eav_v1_first = line_eav && v_bit && !v_last_q;
   assign eav_v0_first = line_eav && !v_bit && v_last_q;
   assign blank_start = eav_v1_first || (ctl2_level && !ctl2_last_q);
   assign blank_end = eav_v0_first || (!ctl2_level && ctl2_last_q);
   assign count_reset = video_mode &&
      (reset_select ? blank_end : blank_start);
   assign count = count_q;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         v_last_q <= 1'b0;
         ctl2_last_q <= 1'b0;
         count_q <= '0;
      end else begin
         ctl2_last_q <= ctl2_level;
         if (line_eav) begin
            v_last_q <= v_bit;
         end
         if (restart || count_reset) begin
            count_q <= '0;
         end else if (line_eav) begin
            count_q <= count_q + 1'b1;
         end
      end
   end

   a_blank_start_reset: assert property (@(posedge clk) disable iff (!reset_n)
      video_mode && !reset_select && eav_v1_first |=> count_q == '0)
      else $error("line count not cleared at blank start");
   a_blank_end_reset: assert property (@(posedge clk) disable iff (!reset_n)
      video_mode && reset_select && eav_v1_first && !restart
      && !blank_end |=> count_q != '0 || $past(count_q) == '1)
      else $error("line count cleared at blank start in end mode");
endmodule
`default_nettype wire

// ---- core/capture_channel_control.sv ----
`timescale 1ns/1ps
`default_nettype none
module capture_channel_control
   import vcap_pkg::*;
#(
   parameter int LINE_BITS = vcap_pkg::LINE_WIDTH
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic video_mode,
   input wire logic line_eav,
   input wire logic v_bit,
   input wire logic f_bit,
   input wire logic second_control_input,
   input wire logic fifo_request,
   input wire logic dma_pending,
   input wire logic field_done,
   input wire logic frame_done,
   input wire logic vint_request,
   output logic dma_event,
   output logic fifo_flush,
   output logic channel_reinit,
   output logic capture_enable,
   output logic field_two,
   output logic [LINE_BITS-1:0] vertical_line_counter,
   output logic line_counter_reset,
   output logic field_irq,
   output logic frame_irq,
   output logic vint_irq
);
   import vcap_pkg::*;

   initial begin
      if (LINE_BITS < 2 || LINE_BITS > 16) begin
         $error("capture_channel_control: LINE_BITS out of range");
      end
   end

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   chan_state_t state_q, state_d;
   logic [31:0] ctl_q, ctl_d;
   logic [STAT_WIDTH-1:0] stat_q, stat_d;
   logic gate_q, gate_d;
   logic field_q;
   logic ctl2_meta_q, ctl2_q;
   logic dma_event_q, field_two_q;
   logic field_irq_q, frame_irq_q, vint_irq_q;

   // APB decode
   wire access = psel && penable;
   wire wr = access && pwrite;
   wire ctl_sel = hit(paddr, CTL_OFFSET);
   wire stat_sel = hit(paddr, STAT_OFFSET);
   wire line_sel = hit(paddr, LINE_OFFSET);
   wire mapped = ctl_sel || stat_sel || line_sel;
   wire ctl_wr = wr && ctl_sel;
   wire stat_wr = wr && stat_sel;

   wire blocked = ctl_q[BLOCK_POS];
   wire in_reset = (state_q != CH_IDLE);
   wire reinit = (state_q == CH_FLUSH);
   wire reset_req = ctl_wr && pwdata[CHAN_RESET_POS];

   // Field mapping applies only to BT.656 / Y/C
   wire mapped_field = video_mode ?
      (f_bit ^ ctl_q[FIELD_INVERT_BIT_POS]) : f_bit;
   wire frame_start = line_eav && field_q && !mapped_field;
   wire [STAT_WIDTH-1:0] stat_set = {frame_done, field_done && field_q,
      field_done && !field_q};
   wire status_live = !blocked && !in_reset;

   assign pready = 1'b1;
   assign pslverr = access && !mapped;
   assign prdata = !access ? 32'h0 :
      ctl_sel ? ctl_q :
      stat_sel ? {{(32-STAT_WIDTH){1'b0}}, stat_q} :
      line_sel ? {{(32-LINE_BITS){1'b0}}, vertical_line_counter} : 32'h0;

   assign dma_event = dma_event_q;
   assign fifo_flush = blocked || reinit;
   assign channel_reinit = reinit;
   assign capture_enable = ctl_q[ENABLE_POS];
   assign field_two = field_two_q;
   assign field_irq = field_irq_q;
   assign frame_irq = frame_irq_q;
   assign vint_irq = vint_irq_q;

   // Channel reset sequence
   always_comb begin
      state_d = state_q;
      case (state_q)
         CH_IDLE: begin
            if (reset_req) begin
               state_d = CH_DRAIN;
            end
         end
         CH_DRAIN: begin
            if (!dma_pending) begin
               state_d = CH_FLUSH;
            end
         end
         CH_FLUSH: state_d = CH_IDLE;
         default: state_d = CH_IDLE;
      endcase
   end

   always_comb begin
      ctl_d = ctl_q;
      if (reinit) begin
         ctl_d = CTL_RESET;
      end else if (ctl_wr && !in_reset) begin
         ctl_d = (pwdata & CTL_WMASK) | (ctl_q & ~CTL_WMASK);
         ctl_d[CHAN_RESET_POS] = pwdata[CHAN_RESET_POS];
      end
   end

   // Set wins over a write-one clear
   always_comb begin
      stat_d = stat_q;
      if (reinit) begin
         stat_d = STAT_RESET;
      end else begin
         if (stat_wr) begin
            stat_d = stat_q & ~pwdata[STAT_WIDTH-1:0];
         end
         if (status_live) begin
            stat_d = stat_d | stat_set;
         end
      end
   end

   // Re-arm only at a frame boundary after unblocking
   always_comb begin
      gate_d = gate_q;
      if (blocked || in_reset) begin
         gate_d = 1'b0;
      end else if (frame_start) begin
         gate_d = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= CH_IDLE;
         ctl_q <= CTL_RESET;
         stat_q <= STAT_RESET;
         gate_q <= 1'b0;
      end else begin
         state_q <= state_d;
         ctl_q <= ctl_d;
         stat_q <= stat_d;
         gate_q <= gate_d;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         field_q <= 1'b0;
         field_two_q <= 1'b0;
      end else if (line_eav) begin
         field_q <= mapped_field;
         field_two_q <= mapped_field;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         dma_event_q <= 1'b0;
         field_irq_q <= 1'b0;
         frame_irq_q <= 1'b0;
         vint_irq_q <= 1'b0;
      end else begin
         dma_event_q <= fifo_request && gate_d && !blocked;
         field_irq_q <= field_done && status_live;
         frame_irq_q <= frame_done && status_live;
         vint_irq_q <= vint_request && status_live;
      end
   end

   // Pin synchroniser; only ctl2_q is read by logic
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ctl2_meta_q <= 1'b0;
         ctl2_q <= 1'b0;
      end else begin
         ctl2_meta_q <= second_control_input;
         ctl2_q <= ctl2_meta_q;
      end
   end

   line_counter #(
      .WIDTH(LINE_BITS)
   ) u_line_counter (
      .clk(clk),
      .reset_n(reset_n),
      .restart(reinit),
      .video_mode(video_mode),
      .reset_select(ctl_q[LINE_COUNTER_RESET_SELECT_POS]),
      .line_eav(line_eav),
      .v_bit(v_bit),
      .ctl2_level(ctl2_q),
      .count(vertical_line_counter),
      .count_reset(line_counter_reset)
   );

   a_reset_waits_dma: assert property (@(posedge clk) disable iff (!reset_n)
      state_q == CH_DRAIN && dma_pending |=> state_q == CH_DRAIN)
      else $error("channel flushed while DMA pending");
   a_reset_no_events: assert property (@(posedge clk) disable iff (!reset_n)
      state_q == CH_DRAIN |=> !dma_event)
      else $error("DMA event during channel reset");
   a_reset_reinit: assert property (@(posedge clk) disable iff (!reset_n)
      reinit |=> ctl_q == CTL_RESET && stat_q == STAT_RESET)
      else $error("channel registers not reinitialised");
   a_reset_selfclear: assert property (@(posedge clk) disable iff (!reset_n)
      reset_req && !in_reset && !dma_pending
      |=> ctl_q[CHAN_RESET_POS] ##1 reinit ##1 !ctl_q[CHAN_RESET_POS])
      else $error("channel reset bit did not clear");
   a_zero_no_reset: assert property (@(posedge clk) disable iff (!reset_n)
      ctl_wr && !pwdata[CHAN_RESET_POS] && !in_reset |=> !in_reset)
      else $error("write of zero started a channel reset");
   a_block_no_events: assert property (@(posedge clk) disable iff (!reset_n)
      blocked |=> !dma_event && (fifo_flush || !blocked))
      else $error("event while capture blocked");
   a_block_status: assert property (@(posedge clk) disable iff (!reset_n)
      blocked && !stat_wr && !in_reset |=> stat_q == $past(stat_q))
      else $error("status updated while blocked");
   a_block_no_irq: assert property (@(posedge clk) disable iff (!reset_n)
      blocked |=> !field_irq && !frame_irq && !vint_irq)
      else $error("interrupt while capture blocked");
   a_unblock_waits: assert property (@(posedge clk) disable iff (!reset_n)
      $fell(blocked) && !frame_start |-> !gate_q ##1 !dma_event)
      else $error("events resumed mid-field");
   a_frame_sync: assert property (@(posedge clk) disable iff (!reset_n)
      !blocked && !in_reset && frame_start |=> gate_q)
      else $error("events not re-armed at frame start");
   a_reserved_zero: assert property (@(posedge clk) disable iff (!reset_n)
      ctl_q[29:21] == 9'h000 && ctl_q[19:18] == 2'h0)
      else $error("reserved control bits set");
   a_field_invert: assert property (@(posedge clk) disable iff (!reset_n)
      line_eav && video_mode |=> field_two == ($past(f_bit) ^
      $past(ctl_q[FIELD_INVERT_BIT_POS])))
      else $error("field polarity mapping wrong");
endmodule
`default_nettype wire

// ---- dv/video_source.sv ----
`timescale 1ns/1ps
`default_nettype none
module video_source #(
   parameter int LEN = 8,
   parameter int LINES = 6
) (
   input wire logic clk,
   input wire logic reset_n,
   output logic line_eav,
   output logic v_bit,
   output logic f_bit,
   output logic ctl2
);
   int cyc_q;
   int line_q;
   logic fld_q;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cyc_q <= 0;
         line_q <= 0;
         fld_q <= 1'b0;
         line_eav <= 1'b0;
         v_bit <= 1'b0;
         f_bit <= 1'b0;
         ctl2 <= 1'b0;
      end else begin
         cyc_q <= (cyc_q == LEN - 1) ? 0 : cyc_q + 1;
         line_eav <= (cyc_q == LEN - 1);
         if (cyc_q == LEN - 1) begin
            v_bit <= (line_q < 2);
            f_bit <= fld_q;
            ctl2 <= (line_q < 2);
            line_q <= (line_q == LINES - 1) ? 0 : line_q + 1;
            if (line_q == LINES - 1) begin
               fld_q <= ~fld_q;
            end
         end else begin
            // Code bits mean nothing off the strobe, so keep them moving
            v_bit <= ~v_bit;
            f_bit <= ~f_bit;
         end
      end
   end
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import vcap_pkg::*;
   logic clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err, video_mode = 1, line_eav, v_bit, f_bit;
   logic second_control_input, fifo_request = 0, dma_pending = 0;
   logic field_done = 0, frame_done = 0, vint_request = 0;
   logic dma_event, fifo_flush, channel_reinit, capture_enable, field_two;
   logic line_counter_reset, field_irq, frame_irq, vint_irq;
   logic [LINE_WIDTH-1:0] vertical_line_counter;
   logic seen = 0, field_invert_bit = 0, vsel = 1, fchk = 0, eav_d = 0, f_d = 0, fprev = 0;
   int fail_count = 0, check_count = 0, fs = 0, hits = 0, reinits = 0;
   always #12.5 clk = ~clk;
   video_source i_src (.clk, .reset_n, .line_eav, .v_bit, .f_bit,
      .ctl2(second_control_input));
   capture_channel_control i_dut (.clk, .reset_n, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .video_mode, .line_eav,
      .v_bit, .f_bit, .second_control_input, .fifo_request, .dma_pending,
      .field_done, .frame_done, .vint_request, .dma_event, .fifo_flush,
      .channel_reinit, .capture_enable, .field_two, .vertical_line_counter,
      .line_counter_reset, .field_irq, .frame_irq, .vint_irq);
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         fail_count++;
         $display("mismatch at %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         fail_count++;
         wrap_up;
      end
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic rdx(input logic [7:0] a, input logic [31:0] e);
      apb(0, a, 32'h0);
      chk(rd, e);
   endtask
   // Waits on dma_event (0) or channel_reinit (1)
   task automatic waitsig(input int k);
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while ((k == 0 ? dma_event : channel_reinit) !== 1'b1 && n < 400);
      if (n >= 400) begin
         fail_count++;
         wrap_up;
      end
   endtask
   task automatic kick;
      repeat (3) begin
         @(posedge clk);
         {field_done, frame_done, vint_request} <= 3'h7;
         @(posedge clk);
         {field_done, frame_done, vint_request} <= 3'h0;
      end
   endtask
   always @(posedge clk) begin
      if (dma_event | field_irq | frame_irq | vint_irq) seen <= 1;
      if (channel_reinit) reinits <= reinits + 1;
      if (line_eav) begin
         if (fprev && !f_bit) fs <= fs + 1;
         fprev <= f_bit;
      end
      eav_d <= line_eav;
      f_d <= f_bit;
      if (fchk && eav_d) chk(field_two, f_d ^ field_invert_bit);
      if (line_counter_reset && line_eav) begin
         chk(v_bit, !vsel);
         hits <= hits + 1;
      end
   end
   initial begin
      repeat (20) @(posedge clk);
      reset_n <= 1;
      rdx(CTL_OFFSET, 32'h40020010);
      fifo_request <= 1;
      kick;
      rdx(STAT_OFFSET, 32'h0);
      chk(seen, 1'b0);
      chk(fifo_flush, 1'b1);
      wr_all: begin
         apb(1, CTL_OFFSET, 32'h7FFFFFFF);
         apb(0, CTL_OFFSET, 32'h0);
         chk(rd & 32'h3FEC0000, 32'h0);
      end
      field_invert_bit = 1;
      // Let a field captured with the old polarity pass first
      repeat (2) @(posedge clk);
      fchk = 1;
      repeat (120) @(posedge clk);
      fchk = 0;
      apb(0, 8'h0C, 32'h0);
      chk(err, 1'b1);
      apb(1, CTL_OFFSET, 32'h00028010);
      apb(1, STAT_OFFSET, 32'h7);
      fs = 0;
      field_invert_bit = 0;
      repeat (2) @(posedge clk);
      fchk = 1;
      waitsig(0);
      chk(fs > 0, 1'b1);
      kick;
      apb(0, STAT_OFFSET, 32'h0);
      chk(rd[2], 1'b1);
      hits = 0;
      repeat (200) @(posedge clk);
      chk(hits > 0, 1'b1);
      apb(1, CTL_OFFSET, 32'h00008010);
      // New select takes effect from the next edge on
      vsel <= 0;
      hits = 0;
      repeat (200) @(posedge clk);
      chk(hits > 0, 1'b1);
      chk(reinits, 0);
      dma_pending <= 1;
      apb(1, CTL_OFFSET, 32'h80000000);
      apb(0, CTL_OFFSET, 32'h0);
      chk(rd[31], 1'b1);
      apb(1, CTL_OFFSET, 32'h00100000);
      repeat (10) @(posedge clk);
      chk(reinits, 0);
      dma_pending <= 0;
      waitsig(1);
      chk(fifo_flush, 1'b1);
      rdx(CTL_OFFSET, 32'h40020010);
      vsel <= 1;
      chk(capture_enable, 1'b0);
      rdx(STAT_OFFSET, 32'h0);
      chk(reinits, 1);
      wrap_up;
   end
endmodule
`default_nettype wire
